// >>> rtl/irf_map.svh
// Register offsets, field positions, reset values and codes of the filter.
`ifndef IRF_MAP_SVH
`define IRF_MAP_SVH

`define IRF_NUM_CTX        4
`define IRF_CTX_STRIDE     16'h0020
`define IRF_CTX_FIELD_MASK 16'h0060
`define IRF_CTX_LSB        5

`define IRF_OFS_CTL_SET    16'h0400
`define IRF_OFS_CTL_CLR    16'h0404
`define IRF_OFS_CMD_PTR    16'h040c
`define IRF_OFS_PTR_LOAD   16'h0418
`define IRF_OFS_MATCH      16'h410c
`define IRF_OFS_MASK_HI    16'h0010
`define IRF_OFS_MASK_LO    16'h0014

`define IRF_CTL_FILL       31
`define IRF_CTL_HDR        30
`define IRF_CTL_CME        29
`define IRF_CTL_MULTI      28
`define IRF_CTL_RUN        15
`define IRF_CTL_WAKE       12
`define IRF_CTL_DEAD       11
`define IRF_CTL_ACTIVE     10
`define IRF_CTL_SPD_LSB    5
`define IRF_CTL_EVT_LSB    0

`define IRF_M_TAG_LSB      28
`define IRF_M_CYC_LSB      12
`define IRF_M_SYNC_LSB     8
`define IRF_M_SGATE        6
`define IRF_M_CHAN_LSB     0
`define IRF_MATCH_WMASK    32'hf1ffff7f
`define IRF_CTL_RMASK      32'hf0009cff

`define IRF_RST_WORD       32'h0000_0000
`define IRF_SPD_100        3'h0
`define IRF_SPD_200        3'h1
`define IRF_SPD_400        3'h2
`define IRF_WAIT_SYNC      2'h3
`define IRF_TAG_01         2'h1
`define IRF_SYNC_HI_OPEN   2'h0

`endif

// >>> rtl/irf_pkg.sv
// Types shared by the receive context filter modules.
package irf_pkg;
	typedef enum logic [2:0] {
		IRF_REG_NONE, IRF_REG_SET, IRF_REG_CLR, IRF_REG_PTR,
		IRF_REG_PTR_LOAD, IRF_REG_MATCH, IRF_REG_MASK_HI, IRF_REG_MASK_LO
	} irf_reg_t;

	typedef struct packed {
		irf_reg_t   kind;
		logic [1:0] ctx;
	} irf_dec_t;

	typedef enum logic [1:0] {
		IRF_ST_IDLE, IRF_ST_WAIT_CYCLE, IRF_ST_RUN
	} irf_start_t;
endpackage

// >>> rtl/irf_ctx_if.sv
// Match settings and packet fields passed from the top to one filter.
`timescale 1ns/1ps
interface irf_ctx_if;
	logic [3:0]  tag_en;
	logic        tag01_sync_gate;
	logic [5:0]  rx_channel_select;
	logic [3:0]  sync_val;
	logic        multi_channel_receive;
	logic [63:0] chan_mask;
	logic [1:0]  desc_wait;
	logic [5:0]  pkt_chan;
	logic [1:0]  pkt_tag;
	logic [3:0]  pkt_sync;
	logic        hit;

	modport cfg (output tag_en, tag01_sync_gate, rx_channel_select, sync_val,
		multi_channel_receive, chan_mask, desc_wait, pkt_chan, pkt_tag,
		pkt_sync, input hit);
	modport filt (input tag_en, tag01_sync_gate, rx_channel_select, sync_val,
		multi_channel_receive, chan_mask, desc_wait, pkt_chan, pkt_tag,
		pkt_sync, output hit);
endinterface

// >>> rtl/irf_ctx_filter.sv
// Packet acceptance decision for one receive context.
`timescale 1ns/1ps
`include "irf_map.svh"
module irf_ctx_filter
	import irf_pkg::*;
(
	irf_ctx_if.filt f // Settings in, hit out.
);
	logic tag_ok;
	logic gate_ok;
	logic chan_ok;
	logic sync_ok;

	always_comb
	begin
		tag_ok  = f.tag_en[f.pkt_tag];
		gate_ok = !(f.pkt_tag == `IRF_TAG_01 && f.tag01_sync_gate &&
			f.tag_en[`IRF_TAG_01]) ||
			(f.pkt_sync[3:2] == `IRF_SYNC_HI_OPEN);
		// The channel field is ignored entirely in multi-channel mode.
		chan_ok = f.multi_channel_receive ? f.chan_mask[f.pkt_chan]
			: (f.pkt_chan == f.rx_channel_select);
		sync_ok = (f.desc_wait != `IRF_WAIT_SYNC) ||
			(f.pkt_sync == f.sync_val);
		f.hit   = tag_ok && gate_ok && chan_ok && sync_ok;
	end
endmodule

// >>> rtl/irf_start_gate.sv
// Start sequencer of one context: waits for run and an optional cycle match.
`timescale 1ns/1ps
`include "irf_map.svh"
module irf_start_gate
	import irf_pkg::*;
(
	input  wire logic        clk_sys,           // System clock.
	input  wire logic        reset_n,           // Asynchronous reset.
	input  wire logic        run,               // Context run bit.
	input  wire logic        cycle_match_en,    // Start on cycle enable.
	input  wire logic        halt,              // Fatal error seen.
	input  wire logic        cyc_start_valid,   // Cycle start received.
	input  wire logic [12:0] cyc_start_count,   // Bus cycle count.
	input  wire logic [12:0] start_cycle_value, // Cycle to start on.
	output logic             active_reg,        // Context is active.
	output logic             start_pulse_reg,   // Became active.
	output logic             cme_clear_reg      // Clear cycle enable.
);
	irf_start_t state_reg;
	irf_start_t state_next;
	logic       cyc_hit;

	assign cyc_hit = cyc_start_valid && cyc_start_count == start_cycle_value;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			IRF_ST_IDLE:
				if (run && !halt)
					state_next = cycle_match_en ? IRF_ST_WAIT_CYCLE : IRF_ST_RUN;
			IRF_ST_WAIT_CYCLE:
				if (!run || halt)
					state_next = IRF_ST_IDLE;
				else if (cyc_hit)
					state_next = IRF_ST_RUN;
			IRF_ST_RUN:
				if (!run || halt)
					state_next = IRF_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg       <= IRF_ST_IDLE;
			active_reg      <= 1'b0;
			start_pulse_reg <= 1'b0;
			cme_clear_reg   <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			active_reg      <= state_next == IRF_ST_RUN;
			start_pulse_reg <= state_reg != IRF_ST_RUN &&
				state_next == IRF_ST_RUN;
			cme_clear_reg   <= state_reg == IRF_ST_WAIT_CYCLE &&
				state_next == IRF_ST_RUN;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_waiting_hit;
		state_reg == IRF_ST_WAIT_CYCLE && run && !halt && cyc_hit;
	endsequence

	a_cycle_start: assert property (s_waiting_hit |=> active_reg)
		else $error("cycle match did not start the context");
	a_wait_hold: assert property (
		state_reg == IRF_ST_WAIT_CYCLE && !cyc_hit |=> !active_reg)
		else $error("context started without a cycle match");
	a_cme_clear: assert property (
		s_waiting_hit |=> cme_clear_reg ##1 !cme_clear_reg)
		else $error("cycle enable clear pulse missing");
endmodule

// >>> rtl/irf_top.sv
// Isochronous receive context registers, start control and packet filters.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "irf_map.svh"
// Overview of operation
// - Speed code of accepted packet reported; codes 3..7 are dropped here, keeping the last valid
// - Completion code stored in low status bits
// - Reserved status and match bits read zero
// - Run fetches first descriptor at pointer
// - Per-context registers at base plus 32n
// - Four tag enables accept tags 11..00
// - Cycle-matched start waits for equal count
// - Sync compared when descriptor waits on 11
// - Tag 01 gate needs upper sync 00
// - Channel field selects accepted channel
// - Multi-channel uses mask, ignores channel
// - Hardware clears cycle enable on start
module irf_top
	import irf_pkg::*;
(
	input  wire logic                  clk_sys,         // 40 MHz clock.
	input  wire logic                  reset_n,         // Async reset.
	input  wire logic [15:0]           paddr,           // APB address.
	input  wire logic                  psel,            // APB select.
	input  wire logic                  penable,         // APB enable.
	input  wire logic                  pwrite,          // APB write.
	input  wire logic [31:0]           pwdata,          // APB write data.
	output logic      [31:0]           prdata,          // APB read data.
	output logic                       pready,          // APB ready.
	output logic                       pslverr,         // APB error.
	input  wire logic                  cyc_start_valid, // Cycle start.
	input  wire logic [12:0]           cyc_start_count, // Cycle count.
	input  wire logic                  pkt_valid,       // Packet strobe.
	input  wire logic [5:0]            pkt_channel,     // Packet channel.
	input  wire logic [1:0]            pkt_tag,         // Packet tag.
	input  wire logic [3:0]            pkt_sync,        // Packet sync.
	input  wire logic [2:0]            pkt_speed,       // Packet speed.
	input  wire logic [3:0][1:0]       desc_wait,       // Wait fields.
	input  wire logic [3:0]            desc_done,       // Input done.
	input  wire logic [3:0][4:0]       desc_event,      // Event codes.
	input  wire logic [3:0]            desc_fatal,      // Fatal errors.
	output logic      [3:0]            pkt_accept,      // Packet taken.
	output logic      [3:0]            ctx_active,      // Active flags.
	output logic      [3:0]            fetch_req,       // Fetch pulse.
	output logic      [3:0][31:0]      fetch_addr,      // Fetch address.
	output logic      [3:0]            packed_buffer_fill, // Fill mode.
	output logic      [3:0]            keep_packet_header  // Header mode.
);
	localparam int NC = `IRF_NUM_CTX;

	function automatic irf_dec_t irf_decode(input logic [15:0] a);
		irf_dec_t d;
		d.ctx = a[`IRF_CTX_LSB +: 2];
		if (a == `IRF_OFS_MASK_HI)
			d.kind = IRF_REG_MASK_HI;
		else if (a == `IRF_OFS_MASK_LO)
			d.kind = IRF_REG_MASK_LO;
		else
			case (a & ~`IRF_CTX_FIELD_MASK)
				`IRF_OFS_CTL_SET:  d.kind = IRF_REG_SET;
				`IRF_OFS_CTL_CLR:  d.kind = IRF_REG_CLR;
				`IRF_OFS_CMD_PTR:  d.kind = IRF_REG_PTR;
				`IRF_OFS_PTR_LOAD: d.kind = IRF_REG_PTR_LOAD;
				`IRF_OFS_MATCH:    d.kind = IRF_REG_MATCH;
				default:           d.kind = IRF_REG_NONE;
			endcase
		return d;
	endfunction

	irf_dec_t         dec;
	logic             acc_first;
	logic             wr_done;
	logic [31:0]      rd_word;
	logic [31:0]      mask_hi_reg;
	logic [31:0]      mask_lo_reg;
	logic [NC-1:0]    run_reg;
	logic [NC-1:0]    cme_reg;
	logic [NC-1:0]    multi_reg;
	logic [NC-1:0]    wake_reg;
	logic [NC-1:0]    dead_reg;
	logic [NC-1:0]    hit;
	logic [NC-1:0]    start_pulse;
	logic [NC-1:0]    cme_clear;
	logic [NC-1:0]    wr_set;
	logic [NC-1:0]    wr_clr;
	logic [NC-1:0][2:0]  spd_reg;
	logic [NC-1:0][4:0]  evt_reg;
	logic [NC-1:0][31:0] match_reg;
	logic [NC-1:0][31:0] ctl_word;

	assign dec       = irf_decode(paddr);
	assign acc_first = psel && penable && !pready;
	// A write lands only at the edge where the master sees pready high.
	assign wr_done   = psel && penable && pready && pwrite;

	// One wait state gives the read mux a full cycle before data is due.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			prdata  <= `IRF_RST_WORD;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc_first;
			pslverr <= acc_first && dec.kind == IRF_REG_NONE;
			if (acc_first)
				prdata <= pwrite ? `IRF_RST_WORD : rd_word;
		end
	end

	always_comb
	begin
		rd_word = `IRF_RST_WORD;
		unique case (dec.kind)
			IRF_REG_SET, IRF_REG_CLR: rd_word = ctl_word[dec.ctx];
			IRF_REG_PTR, IRF_REG_PTR_LOAD: rd_word = fetch_addr[dec.ctx];
			IRF_REG_MATCH:   rd_word = match_reg[dec.ctx];
			IRF_REG_MASK_HI: rd_word = mask_hi_reg;
			IRF_REG_MASK_LO: rd_word = mask_lo_reg;
			IRF_REG_NONE:    rd_word = `IRF_RST_WORD;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mask_hi_reg <= `IRF_RST_WORD;
			mask_lo_reg <= `IRF_RST_WORD;
		end
		else if (wr_done && dec.kind == IRF_REG_MASK_HI)
			mask_hi_reg <= pwdata;
		else if (wr_done && dec.kind == IRF_REG_MASK_LO)
			mask_lo_reg <= pwdata;
	end

	genvar i;
	generate
		for (i = 0; i < NC; i++)
		begin : g_ctx
			irf_ctx_if u_if ();

			assign wr_set[i] = wr_done && dec.kind == IRF_REG_SET &&
				dec.ctx == i[1:0];
			assign wr_clr[i] = wr_done && dec.kind == IRF_REG_CLR &&
				dec.ctx == i[1:0];

			always_comb
			begin
				ctl_word[i] = `IRF_RST_WORD;
				ctl_word[i][`IRF_CTL_FILL]   = packed_buffer_fill[i];
				ctl_word[i][`IRF_CTL_HDR]    = keep_packet_header[i];
				ctl_word[i][`IRF_CTL_CME]    = cme_reg[i];
				ctl_word[i][`IRF_CTL_MULTI]  = multi_reg[i];
				ctl_word[i][`IRF_CTL_RUN]    = run_reg[i];
				ctl_word[i][`IRF_CTL_WAKE]   = wake_reg[i];
				ctl_word[i][`IRF_CTL_DEAD]   = dead_reg[i];
				ctl_word[i][`IRF_CTL_ACTIVE] = ctx_active[i];
				ctl_word[i][`IRF_CTL_SPD_LSB +: 3] = spd_reg[i];
				ctl_word[i][`IRF_CTL_EVT_LSB +: 5] = evt_reg[i];
			end

			// Mode bits are plain set/clear; software keeps them still
			// while running, so no interlock is spent on them here.
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					run_reg[i]            <= 1'b0;
					packed_buffer_fill[i] <= 1'b0;
					keep_packet_header[i] <= 1'b0;
					multi_reg[i]          <= 1'b0;
				end
				else if (wr_set[i])
				begin
					run_reg[i] <= run_reg[i] | pwdata[`IRF_CTL_RUN];
					packed_buffer_fill[i] <= packed_buffer_fill[i] |
						pwdata[`IRF_CTL_FILL];
					keep_packet_header[i] <= keep_packet_header[i] |
						pwdata[`IRF_CTL_HDR];
					multi_reg[i] <= multi_reg[i] | pwdata[`IRF_CTL_MULTI];
				end
				else if (wr_clr[i])
				begin
					run_reg[i] <= run_reg[i] & ~pwdata[`IRF_CTL_RUN];
					packed_buffer_fill[i] <= packed_buffer_fill[i] &
						~pwdata[`IRF_CTL_FILL];
					keep_packet_header[i] <= keep_packet_header[i] &
						~pwdata[`IRF_CTL_HDR];
					multi_reg[i] <= multi_reg[i] & ~pwdata[`IRF_CTL_MULTI];
				end
			end

			// Hardware sets and software sets win over any clear.
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					cme_reg[i]  <= 1'b0;
					wake_reg[i] <= 1'b0;
					dead_reg[i] <= 1'b0;
				end
				else
				begin
					if (wr_set[i] && pwdata[`IRF_CTL_CME])
						cme_reg[i] <= 1'b1;
					else if (cme_clear[i] || (wr_clr[i] && pwdata[`IRF_CTL_CME]))
						cme_reg[i] <= 1'b0;
					if (wr_set[i] && pwdata[`IRF_CTL_WAKE])
						wake_reg[i] <= 1'b1;
					else if (fetch_req[i])
						wake_reg[i] <= 1'b0;
					if (desc_fatal[i])
						dead_reg[i] <= 1'b1;
					else if (wr_clr[i] && pwdata[`IRF_CTL_RUN])
						dead_reg[i] <= 1'b0;
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					spd_reg[i] <= `IRF_SPD_100;
					evt_reg[i] <= 5'h00;
				end
				else
				begin
					// Reserved speed codes are dropped, keeping the last valid.
					if (pkt_valid && hit[i] && ctx_active[i] &&
						pkt_speed <= `IRF_SPD_400)
						spd_reg[i] <= pkt_speed;
					if (desc_done[i])
						evt_reg[i] <= desc_event[i];
				end
			end

			// The pointer is read-only to the match path; it only loads
			// while the context is stopped, so a fetch never sees it move.
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					fetch_addr[i] <= `IRF_RST_WORD;
					match_reg[i]  <= `IRF_RST_WORD;
				end
				else
				begin
					if (wr_done && dec.kind == IRF_REG_PTR_LOAD &&
						dec.ctx == i[1:0] && !run_reg[i])
						fetch_addr[i] <= pwdata;
					if (wr_done && dec.kind == IRF_REG_MATCH && dec.ctx == i[1:0])
						match_reg[i] <= pwdata & `IRF_MATCH_WMASK;
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					pkt_accept[i] <= 1'b0;
					fetch_req[i]  <= 1'b0;
				end
				else
				begin
					pkt_accept[i] <= pkt_valid && hit[i] && ctx_active[i];
					fetch_req[i]  <= start_pulse[i];
				end
			end

			assign u_if.tag_en            = match_reg[i][`IRF_M_TAG_LSB +: 4];
			assign u_if.tag01_sync_gate   = match_reg[i][`IRF_M_SGATE];
			assign u_if.rx_channel_select = match_reg[i][`IRF_M_CHAN_LSB +: 6];
			assign u_if.sync_val          = match_reg[i][`IRF_M_SYNC_LSB +: 4];
			assign u_if.multi_channel_receive = multi_reg[i];
			assign u_if.chan_mask         = {mask_hi_reg, mask_lo_reg};
			assign u_if.desc_wait         = desc_wait[i];
			assign u_if.pkt_chan          = pkt_channel;
			assign u_if.pkt_tag           = pkt_tag;
			assign u_if.pkt_sync          = pkt_sync;
			assign hit[i]                 = u_if.hit;

			irf_ctx_filter u_filter (
				.f (u_if.filt)
			);

			irf_start_gate u_start (
				.clk_sys           (clk_sys),
				.reset_n           (reset_n),
				.run               (run_reg[i]),
				.cycle_match_en    (cme_reg[i]),
				.halt              (dead_reg[i]),
				.cyc_start_valid   (cyc_start_valid),
				.cyc_start_count   (cyc_start_count),
				.start_cycle_value (match_reg[i][`IRF_M_CYC_LSB +: 13]),
				.active_reg        (ctx_active[i]),
				.start_pulse_reg   (start_pulse[i]),
				.cme_clear_reg     (cme_clear[i])
			);
		end
	endgenerate

	logic [63:0] u_chk_mask;
	logic        u_chk_tag;
	assign u_chk_mask = {mask_hi_reg, mask_lo_reg};
	assign u_chk_tag  = match_reg[0][`IRF_M_TAG_LSB + pkt_tag];

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_take0;
		pkt_valid && ctx_active[0] && hit[0];
	endsequence

	a_speed_report: assert property (
		s_take0 ##0 pkt_speed <= `IRF_SPD_400
		|=> spd_reg[0] == $past(pkt_speed) && pkt_accept[0])
		else $error("speed field not taken from accepted packet");
	a_event_store: assert property (
		desc_done[0] |=> evt_reg[0] == $past(desc_event[0]))
		else $error("event code not stored");
	a_rsvd_zero: assert property (
		acc_first && !pwrite && dec.kind inside {IRF_REG_MATCH, IRF_REG_SET}
		|=> (prdata & ~(dec.kind == IRF_REG_MATCH ? `IRF_MATCH_WMASK :
		`IRF_CTL_RMASK)) == 32'h0)
		else $error("reserved bits read nonzero");
	a_fetch_start: assert property (
		$rose(ctx_active[0]) |=> fetch_req[0] ##1 !fetch_req[0])
		else $error("no descriptor fetch on start");
	a_ctx_stride: assert property (
		wr_done && paddr == `IRF_OFS_CTL_SET + `IRF_CTX_STRIDE &&
		pwdata[`IRF_CTL_RUN] |=> run_reg[1])
		else $error("context 1 run not set at stride offset");
	a_tag_enable: assert property (
		pkt_accept[0] |-> $past(u_chk_tag))
		else $error("packet accepted with tag disabled");
	a_sync_wait: assert property (
		s_take0 ##0 desc_wait[0] == `IRF_WAIT_SYNC
		|-> pkt_sync == match_reg[0][`IRF_M_SYNC_LSB +: 4])
		else $error("sync mismatch accepted while waiting");
	a_tag01_gate: assert property (
		s_take0 ##0 pkt_tag == `IRF_TAG_01 && match_reg[0][`IRF_M_SGATE]
		|-> pkt_sync[3:2] == `IRF_SYNC_HI_OPEN)
		else $error("tag 01 packet passed the sync gate");
	a_single_chan: assert property (
		s_take0 ##0 !multi_reg[0]
		|-> pkt_channel == match_reg[0][`IRF_M_CHAN_LSB +: 6])
		else $error("wrong channel accepted");
	a_multi_chan: assert property (
		s_take0 ##0 multi_reg[0] |-> u_chk_mask[pkt_channel])
		else $error("masked channel accepted");
endmodule

// >>> tb/irf_link_model.sv
// Link layer stand-in that sends cycle starts and isochronous headers.
`timescale 1ns/1ps
module irf_link_model
(
	input  wire logic        clk_sys,         // System clock.
	output logic             cyc_start_valid, // Cycle start pulse.
	output logic      [12:0] cyc_start_count, // Bus cycle count.
	output logic             pkt_valid,       // Header strobe.
	output logic      [5:0]  pkt_channel,     // Channel number.
	output logic      [1:0]  pkt_tag,         // Tag field.
	output logic      [3:0]  pkt_sync,        // Sync field.
	output logic      [2:0]  pkt_speed        // Speed code.
);
	initial
	begin
		cyc_start_valid = 1'b0;
		cyc_start_count = 13'h0000;
		pkt_valid = 1'b0;
		{pkt_channel, pkt_tag, pkt_sync, pkt_speed} = 15'h0000;
	end

	// Fields mean nothing without their strobe, so they are inverted after it
	// to expose any logic that samples them late.
	task automatic send_cycle(input logic [12:0] cnt);
		@(posedge clk_sys);
		cyc_start_valid <= 1'b1;
		cyc_start_count <= cnt;
		@(posedge clk_sys);
		cyc_start_valid <= 1'b0;
		cyc_start_count <= ~cnt;
	endtask

	task automatic send_pkt(input logic [5:0] ch, input logic [1:0] tg,
		input logic [3:0] sy, input logic [2:0] sp);
		@(posedge clk_sys);
		pkt_valid <= 1'b1;
		{pkt_channel, pkt_tag, pkt_sync, pkt_speed} <= {ch, tg, sy, sp};
		@(posedge clk_sys);
		pkt_valid <= 1'b0;
		{pkt_channel, pkt_tag, pkt_sync, pkt_speed} <= ~{ch, tg, sy, sp};
	endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the receive context filter.
`timescale 1ns/1ps
`include "irf_map.svh"
module tb_top;
	logic             clk_sys, reset_n, psel, penable, pwrite, pready;
	logic             pslverr, cyc_start_valid, pkt_valid;
	logic [15:0]      paddr, o;
	logic [31:0]      pwdata, prdata, rd;
	logic [12:0]      cyc_start_count;
	logic [5:0]       pkt_channel, ch;
	logic [1:0]       pkt_tag, tg;
	logic [3:0]       pkt_sync, sy;
	logic [2:0]       pkt_speed;
	logic [3:0][1:0]  desc_wait;
	logic [3:0][4:0]  desc_event;
	logic [3:0][31:0] fetch_addr;
	logic [3:0]       desc_done, desc_fatal, pkt_accept, ctx_active;
	logic [3:0]       fetch_req, fill_mode, hdr_mode, act_m, multi_m;
	logic [31:0]      match_m [4];
	logic [63:0]      mask_m;
	logic             er;
	int               num_errors, comparisons, i, s;

	irf_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cyc_start_valid(cyc_start_valid), .cyc_start_count(cyc_start_count),
		.pkt_valid(pkt_valid), .pkt_channel(pkt_channel), .pkt_tag(pkt_tag),
		.pkt_sync(pkt_sync), .pkt_speed(pkt_speed), .desc_wait(desc_wait),
		.desc_done(desc_done), .desc_event(desc_event),
		.desc_fatal(desc_fatal), .pkt_accept(pkt_accept),
		.ctx_active(ctx_active), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .packed_buffer_fill(fill_mode),
		.keep_packet_header(hdr_mode));

	irf_link_model i_link (.clk_sys(clk_sys),
		.cyc_start_valid(cyc_start_valid), .cyc_start_count(cyc_start_count),
		.pkt_valid(pkt_valid), .pkt_channel(pkt_channel), .pkt_tag(pkt_tag),
		.pkt_sync(pkt_sync), .pkt_speed(pkt_speed));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic end_sim;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#500000;
		num_errors++;
		end_sim();
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		{paddr, pwrite, pwdata} <= {a, wr, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			check("pready", {31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp,
		input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask

	// Starting a context must fetch from the loaded pointer.
	task automatic start_ctx(input int c);
		int n;
		apb(1'b1, `IRF_OFS_CTL_SET + 16'(c * 32), 32'h0000_8000);
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (fetch_req[c] !== 1'b1 && n < 10);
		check("fetch req", {31'h0, fetch_req[c]}, 32'h1);
		check("fetch addr", fetch_addr[c], {16'h1000, 16'(c * 32)});
		check("active", {31'h0, ctx_active[c]}, 32'h1);
		act_m[c] = 1'b1;
	endtask

	function automatic logic [3:0] exp_acc(input logic [5:0] c_ch,
		input logic [1:0] c_tg, input logic [3:0] c_sy);
		logic [3:0] r;
		for (int c = 0; c < 4; c++)
		begin
			r[c] = act_m[c] && match_m[c][28 + c_tg]
				&& !(match_m[c][6] && c_tg == 2'b01 && c_sy[3:2] != 2'b00)
				&& (multi_m[c] ? mask_m[c_ch] : c_ch == match_m[c][5:0])
				&& (desc_wait[c] != 2'b11 || c_sy == match_m[c][11:8]);
		end
		return r;
	endfunction

	task automatic pkt(input logic [5:0] c, input logic [1:0] t,
		input logic [3:0] y, input logic [2:0] p);
		logic [3:0] e;
		i_link.send_pkt(c, t, y, p);
		#1;
		e = exp_acc(c, t, y);
		check("accept", 32'(pkt_accept), 32'(e));
	endtask

	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = 52'h0;
		{desc_wait, desc_done, desc_event, desc_fatal} = 36'h0;
		{num_errors, comparisons, act_m, multi_m, mask_m} = 0;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		void'($urandom(29));
		for (i = 0; i < 4; i++)
		begin
			o = 16'(i * 32);
			rdchk(`IRF_OFS_MATCH + o, 32'h0, "match rst");
			apb(1'b1, `IRF_OFS_MATCH + o, 32'hffff_ffff);
			match_m[i] = `IRF_MATCH_WMASK;
			rdchk(`IRF_OFS_MATCH + o, match_m[i], "match");
			apb(1'b1, `IRF_OFS_PTR_LOAD + o, {16'h1000, o});
			apb(1'b1, `IRF_OFS_CMD_PTR + o, 32'hdead_beef);
			rdchk(`IRF_OFS_CMD_PTR + o, {16'h1000, o}, "ptr");
			rdchk(`IRF_OFS_CTL_CLR + o, 32'h0, "ctl rst");
		end
		apb(1'b0, 16'h0030, 32'h0);
		check("unmapped", {31'h0, er}, 32'h1);
		apb(1'b1, `IRF_OFS_MASK_LO, 32'h0000_00f0);
		apb(1'b1, `IRF_OFS_MASK_HI, 32'h8000_0001);
		mask_m = 64'h8000_0001_0000_00f0;
		apb(1'b1, `IRF_OFS_CTL_SET + 16'h0020, 32'h1000_0000);
		multi_m[1] = 1'b1;
		start_ctx(0);
		start_ctx(1);
		apb(1'b1, `IRF_OFS_PTR_LOAD, 32'h0);
		rdchk(`IRF_OFS_CMD_PTR, 32'h1000_0000, "ptr held");
		for (i = 0; i < 96; i++)
		begin
			if (i % 12 == 0)
			begin
				match_m[0] = $urandom & `IRF_MATCH_WMASK;
				apb(1'b1, `IRF_OFS_MATCH, match_m[0]);
			end
			@(posedge clk_sys);
			desc_wait <= 8'($urandom);
			ch = ($urandom % 2) ? match_m[0][5:0] : 6'($urandom);
			tg = 2'($urandom);
			sy = 4'($urandom);
			pkt(ch, tg, sy, 3'($urandom % 3));
		end
		match_m[0] = 32'h1000_0005;
		apb(1'b1, `IRF_OFS_MATCH, match_m[0]);
		desc_wait <= 8'h00;
		for (s = 0; s < 3; s++)
		begin
			pkt(6'h05, 2'b00, 4'h0, 3'(s));
			pkt(6'h05, 2'b00, 4'h0, 3'(s + 3));
			@(posedge clk_sys);
			desc_done <= 4'h1;
			desc_event[0] <= 5'(5'h11 + s);
			@(posedge clk_sys);
			desc_done <= 4'h0;
			rdchk(`IRF_OFS_CTL_SET, 32'h8400 | 32'(s << 5) | 32'(5'h11 + s),
				"status");
		end
		match_m[2] = 32'h11ab_c009;
		apb(1'b1, `IRF_OFS_MATCH + 16'h0040, match_m[2]);
		apb(1'b1, `IRF_OFS_CTL_SET + 16'h0040, 32'h2000_0000);
		apb(1'b1, `IRF_OFS_CTL_SET + 16'h0040, 32'h0000_8000);
		i_link.send_cycle(13'h1abb);
		repeat (3) @(posedge clk_sys);
		pkt(6'h09, 2'b00, 4'h0, 3'h0);
		i_link.send_cycle(13'h1abc);
		repeat (3) @(posedge clk_sys);
		#1;
		check("cycle start", {31'h0, ctx_active[2]}, 32'h1);
		act_m[2] = 1'b1;
		rdchk(`IRF_OFS_CTL_CLR + 16'h0040, 32'h0000_8400, "cme clear");
		pkt(6'h09, 2'b00, 4'h0, 3'h0);
		// A fatal error stops the context; clearing run clears dead.
		@(posedge clk_sys);
		desc_fatal <= 4'h4;
		@(posedge clk_sys);
		desc_fatal <= 4'h0;
		rdchk(`IRF_OFS_CTL_SET + 16'h0040, 32'h0000_8800, "dead");
		apb(1'b1, `IRF_OFS_CTL_CLR + 16'h0040, 32'h0000_8000);
		rdchk(`IRF_OFS_CTL_SET + 16'h0040, 32'h0, "dead clr");
		// Mode bits are changed only while the context is stopped.
		apb(1'b1, `IRF_OFS_CTL_SET + 16'h0060, 32'hc000_0000);
		rdchk(`IRF_OFS_CTL_CLR + 16'h0060, 32'hc000_0000, "modes");
		check("fill", 32'(fill_mode), 32'h8);
		check("hdr", 32'(hdr_mode), 32'h8);
		apb(1'b1, `IRF_OFS_CTL_CLR + 16'h0060, 32'h4000_0000);
		rdchk(`IRF_OFS_CTL_SET + 16'h0060, 32'h8000_0000, "modes clr");
		check("hdr clr", 32'(hdr_mode), 32'h0);
		end_sim();
	end
endmodule
